// >>> pkg/nbp_pkg.sv
// Purpose: shared constants for the block protection host controller
// Assumes: 16-bit flash data bus, word addressing, apb control registers
// Notes: command codes and unlock addresses of the flash command sets
package nbp_pkg;
   // apb register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;   // command code and start strobe
   localparam logic [7:0] REG_ADDR = 8'h04;   // block or word address
   localparam logic [7:0] REG_DATA = 8'h08;   // program data
   localparam logic [7:0] REG_STAT = 8'h0C;   // busy, mode and read data
   localparam logic [7:0] REG_PINS = 8'h10;   // write protect and accel level
   // control field layout
   localparam int CTRL_OP_LSB = 0;
   localparam int CTRL_OP_W = 4;
   // flash bus widths
   localparam int FA_W = 23;
   localparam int FD_W = 16;
   // unlock addresses and data
   localparam logic [FA_W-1:0] ADDR_555 = 23'h00_0555;
   localparam logic [FA_W-1:0] ADDR_2AA = 23'h00_02AA;
   localparam logic [FD_W-1:0] DAT_AA = 16'h00AA;
   localparam logic [FD_W-1:0] DAT_55 = 16'h0055;
   // command set codes
   localparam logic [FD_W-1:0] CMD_VOL_SET = 16'h00E0;
   localparam logic [FD_W-1:0] CMD_PROG = 16'h00A0;
   localparam logic [FD_W-1:0] CMD_EXT_ENTER = 16'h0088;
   localparam logic [FD_W-1:0] CMD_EXIT_90 = 16'h0090;
   localparam logic [FD_W-1:0] CMD_EXIT_00 = 16'h0000;
   localparam logic [FD_W-1:0] VBIT_PROTECT = 16'h0000;
   localparam logic [FD_W-1:0] VBIT_CLEAR = 16'h0001;
   // status read encodings
   localparam logic [FD_W-1:0] STAT_PROTECTED = 16'h0000;
   localparam logic [FD_W-1:0] STAT_UNPROT = 16'h0001;
   // last word address of the extended block area
   localparam logic [FA_W-1:0] EXT_LAST = 23'h00_00FF;
   // host operations
   typedef enum logic [3:0]
   {
      OP_VOL_ENTER = 4'h1,
      OP_VOL_PROG = 4'h2,
      OP_VOL_CLEAR = 4'h3,
      OP_VOL_READ = 4'h4,
      OP_EXT_ENTER = 4'h5,
      OP_EXT_READ = 4'h6,
      OP_EXT_PROG = 4'h7,
      OP_EXT_EXIT = 4'h8,
      OP_PROT_EXIT = 4'h9
   } nbp_op_t;
   // bus cycle timing: we# low and read access, in ns and cycles at 40 MHz
   localparam int CLK_MHZ = 40;
   localparam int T_WP_NS = 50;
   localparam int T_WP_CYC = (T_WP_NS * CLK_MHZ + 999) / 1000;
   localparam int T_RD_NS = 80;
   localparam int T_RD_CYC = (T_RD_NS * CLK_MHZ + 999) / 1000;
endpackage : nbp_pkg

// >>> rtl/nbp_apb_regs.sv
// Purpose: apb slave holding the controller's own registers
// Assumes: zero wait states, one aligned word per register
// Notes: a ctrl write launches an operation while the sequencer is idle
`timescale 1ns/1ps
module nbp_apb_regs
   import nbp_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic busy,
   input wire logic vol_mode,
   input wire logic ext_mode,
   input wire logic [FD_W-1:0] rd_data,
   output logic start,
   output logic [CTRL_OP_W-1:0] op,
   output logic [FA_W-1:0] addr,
   output logic [FD_W-1:0] wdata,
   output logic wp_high,
   output logic accel_req
);
   ////////////////////////////////////////////////////////////////////
   // decode
   wire access = psel & penable;           // access phase
   wire wr = access & pwrite;              // write strobe
   wire hit_ctrl = paddr == REG_CTRL;
   wire hit_addr = paddr == REG_ADDR;
   wire hit_data = paddr == REG_DATA;
   wire hit_stat = paddr == REG_STAT;
   wire hit_pins = paddr == REG_PINS;
   wire mapped = hit_ctrl | hit_addr | hit_data | hit_stat | hit_pins;
   assign pready = 1'b1;                   // always ready
   assign pslverr = access & ~mapped;      // unmapped answers error
   ////////////////////////////////////////////////////////////////////
   // write side
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         start <= 1'b0;
         op <= 4'h0;
         addr <= 23'h00_0000;
         wdata <= 16'h0000;
         wp_high <= 1'b0;
         accel_req <= 1'b0;
      end
      else
      begin
         start <= wr & hit_ctrl & ~busy;   // ignored while busy
         if (wr & hit_ctrl & ~busy)
            op <= pwdata[CTRL_OP_LSB +: CTRL_OP_W];
         if (wr & hit_addr)
            addr <= pwdata[FA_W-1:0];
         if (wr & hit_data)
            wdata <= pwdata[FD_W-1:0];
         if (wr & hit_pins)
         begin
            wp_high <= pwdata[0];
            accel_req <= pwdata[1];
         end
      end
   end
   ////////////////////////////////////////////////////////////////////
   // read mux
   always_comb
   begin
      prdata = 32'h0000_0000;
      if (hit_stat)
         prdata = {13'h0000, ext_mode, vol_mode, busy, rd_data};
      else if (hit_ctrl)
         prdata = {28'h000_0000, op};
      else if (hit_addr)
         prdata = {9'h000, addr};
      else if (hit_data)
         prdata = {16'h0000, wdata};
      else if (hit_pins)
         prdata = {30'h0000_0000, accel_req, wp_high};
   end
endmodule : nbp_apb_regs

// >>> rtl/nbp_bus_cycle.sv
// Purpose: one asynchronous flash write or read cycle
// Assumes: chip enable driven low here for each cycle, timing from package
// Notes: read data is captured at the end of the access time
`timescale 1ns/1ps
module nbp_bus_cycle
   import nbp_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic go,
   input wire logic is_read,
   input wire logic [FA_W-1:0] a_in,
   input wire logic [FD_W-1:0] d_in,
   output logic done,
   output logic [FA_W-1:0] fa,
   output logic [FD_W-1:0] dq_out,
   output logic dq_oe,
   input wire logic [FD_W-1:0] dq_in,
   output logic ce_n,
   output logic we_n,
   output logic oe_n,
   output logic [FD_W-1:0] rdat
);
   ////////////////////////////////////////////////////////////////////
   // cycle counter
   logic [3:0] cnt; // cycles left in current strobe
   logic active;    // a cycle is running
   logic rd;        // the running cycle reads
   wire last = active & (cnt == 4'h0);
   assign done = last;
   // strobe and data pins follow the running cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         active <= 1'b0;
         rd <= 1'b0;
         cnt <= 4'h0;
         fa <= 23'h00_0000;
         dq_out <= 16'h0000;
         dq_oe <= 1'b0;
         ce_n <= 1'b1;
         we_n <= 1'b1;
         oe_n <= 1'b1;
         rdat <= 16'h0000;
      end
      else if (go & ~active)
      begin
         active <= 1'b1;
         rd <= is_read;
         cnt <= is_read ? 4'(T_RD_CYC - 1) : 4'(T_WP_CYC - 1);
         fa <= a_in;
         dq_out <= d_in;
         dq_oe <= ~is_read;
         ce_n <= 1'b0;
         we_n <= is_read;
         oe_n <= ~is_read;
      end
      else if (last)
      begin
         active <= 1'b0;
         if (rd)
            rdat <= dq_in;
         dq_oe <= 1'b0;
         ce_n <= 1'b1;
         we_n <= 1'b1;
         oe_n <= 1'b1;
      end
      else if (active)
         cnt <= cnt - 4'h1;
   end
endmodule : nbp_bus_cycle

// >>> rtl/nbp_host.sv
// Purpose: host controller issuing block protection command sequences
// Assumes: software programs the apb registers, one operation at a time
// Notes: a new operation is refused until the previous one completes
//
// What this block does
// - enter volatile set before volatile commands
// - enter extended mode with three writes
// - no erase commands in extended mode
// - acceleration level only from read mode
`timescale 1ns/1ps
module nbp_host
   import nbp_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [FA_W-1:0] flash_addr,
   output logic [FD_W-1:0] flash_dq_out,
   output logic flash_dq_oe,
   input wire logic [FD_W-1:0] flash_dq_in,
   output logic flash_ce_n,
   output logic flash_we_n,
   output logic flash_oe_n,
   output logic flash_wp_high,
   output logic acceleration_voltage_level
);
   ////////////////////////////////////////////////////////////////////
   // state and registers
   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_ISSUE = 2'b01,
      ST_WAIT = 2'b10
   } nbp_state_t;
   nbp_state_t state;        // sequencer state
   nbp_state_t next_state;   // next sequencer state
   logic [2:0] step;         // index of current bus cycle
   logic [2:0] nsteps;       // bus cycles in the sequence
   logic vol_mode;           // volatile command set entered
   logic ext_mode;           // extended block mode entered
   logic start;              // software launched an operation
   logic [CTRL_OP_W-1:0] op; // operation code
   logic [FA_W-1:0] addr;    // target address
   logic [FD_W-1:0] wdata;   // program data
   logic wp_high;            // write protect pin level request
   logic accel_req;          // acceleration level request
   logic cyc_done;           // current bus cycle finished
   logic [FD_W-1:0] rdat;    // last read data
   logic cyc_go;             // launch a bus cycle
   logic cyc_rd;             // launched cycle reads
   logic [FA_W-1:0] cyc_a;   // launched cycle address
   logic [FD_W-1:0] cyc_d;   // launched cycle data
   // busy holds off ctrl writes until the last cycle ends
   wire busy = state != ST_IDLE;

   ////////////////////////////////////////////////////////////////////
   // register block
   nbp_apb_regs u_regs
   (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .busy(busy),
      .vol_mode(vol_mode),
      .ext_mode(ext_mode),
      .rd_data(rdat),
      .start(start),
      .op(op),
      .addr(addr),
      .wdata(wdata),
      .wp_high(wp_high),
      .accel_req(accel_req)
   );
   ////////////////////////////////////////////////////////////////////
   // bus cycle engine
   nbp_bus_cycle u_cyc
   (
      .pclk(pclk),
      .presetn(presetn),
      .go(cyc_go),
      .is_read(cyc_rd),
      .a_in(cyc_a),
      .d_in(cyc_d),
      .done(cyc_done),
      .fa(flash_addr),
      .dq_out(flash_dq_out),
      .dq_oe(flash_dq_oe),
      .dq_in(flash_dq_in),
      .ce_n(flash_ce_n),
      .we_n(flash_we_n),
      .oe_n(flash_oe_n),
      .rdat(rdat)
   );
   ////////////////////////////////////////////////////////////////////
   // operation legality against current mode
   wire op_vol = (op == OP_VOL_PROG) | (op == OP_VOL_CLEAR) | (op == OP_VOL_READ);
   wire op_ext = (op == OP_EXT_READ) | (op == OP_EXT_PROG) | (op == OP_EXT_EXIT);
   wire in_ext_area = addr <= EXT_LAST;
   // a refused op starts nothing: busy never rises
   // volatile commands only after enter
   // extended access only after enter and inside the block
   wire legal = op_vol ? vol_mode :
                op_ext ? (ext_mode & ((op == OP_EXT_EXIT) | in_ext_area)) :
                (op == OP_VOL_ENTER) | (op == OP_EXT_ENTER) | (op == OP_PROT_EXIT);
   // number of bus cycles per operation
   // extended exit is the unlock pair, 90, then one write of 00
   assign nsteps = (op == OP_EXT_ENTER) ? 3'd3 :
                   (op == OP_EXT_EXIT) ? 3'd4 :
                   (op == OP_VOL_READ) | (op == OP_EXT_READ) ? 3'd1 :
                   (op == OP_VOL_ENTER) ? 3'd3 : 3'd2;
   // no op erases, so none reaches the block in extended mode

   ////////////////////////////////////////////////////////////////////
   // unlock prefix cycle selection
   function automatic logic [FA_W+FD_W-1:0] unlock_cyc(input logic [2:0] s, input logic [FD_W-1:0] code);
      unlock_cyc = (s == 3'd0) ? {ADDR_555, DAT_AA} :
                   (s == 3'd1) ? {ADDR_2AA, DAT_55} : {ADDR_555, code};
   endfunction : unlock_cyc

   // steps 0 and 1 send the unlock pair, step 2 the code
   // address, data and direction of the current step
   always_comb
   begin
      cyc_rd = 1'b0;
      cyc_a = addr;
      cyc_d = wdata;
      unique case (nbp_op_t'(op))
         OP_VOL_ENTER: {cyc_a, cyc_d} = unlock_cyc(step, CMD_VOL_SET);
         OP_EXT_ENTER: {cyc_a, cyc_d} = unlock_cyc(step, CMD_EXT_ENTER);
         OP_EXT_EXIT:
         begin
            // the closing write carries 00 at a don't-care address
            if (step < 3'd3)
               {cyc_a, cyc_d} = unlock_cyc(step, CMD_EXIT_90);
            else
               cyc_d = CMD_EXIT_00;
         end
         OP_PROT_EXIT: cyc_d = (step == 3'd0) ? CMD_EXIT_90 : CMD_EXIT_00;
         OP_VOL_PROG: cyc_d = (step == 3'd0) ? CMD_PROG : VBIT_PROTECT;
         OP_VOL_CLEAR: cyc_d = (step == 3'd0) ? CMD_PROG : VBIT_CLEAR;
         OP_VOL_READ: cyc_rd = 1'b1;
         OP_EXT_READ: cyc_rd = 1'b1;
         OP_EXT_PROG: cyc_d = (step == 3'd0) ? CMD_PROG : wdata;
         default: cyc_rd = 1'b1;
      endcase
   end
   // issue lasts one cycle, so each step launches once
   assign cyc_go = state == ST_ISSUE;

   ////////////////////////////////////////////////////////////////////
   // sequencer: one operation at a time
   always_comb
   begin
      next_state = state;
      unique case (state)
         ST_IDLE: if (start & legal) next_state = ST_ISSUE;
         ST_ISSUE: next_state = ST_WAIT;
         ST_WAIT: if (cyc_done) next_state = (step + 3'd1 == nsteps) ? ST_IDLE : ST_ISSUE;
         default: next_state = ST_IDLE;
      endcase
   end
   // state, step and mode tracking
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state <= ST_IDLE;
         step <= 3'd0;
         vol_mode <= 1'b0;
         ext_mode <= 1'b0;
      end
      else
      begin
         state <= next_state;
         // step restarts at zero while the sequencer rests
         if (state == ST_IDLE)
            step <= 3'd0;
         else if (state == ST_WAIT && cyc_done)
            step <= step + 3'd1;
         // modes change once the whole sequence has gone out
         if (state == ST_WAIT && cyc_done && step + 3'd1 == nsteps)
         begin
            if (op == OP_VOL_ENTER)
               vol_mode <= 1'b1;
            if (op == OP_PROT_EXIT)
               vol_mode <= 1'b0;
            if (op == OP_EXT_ENTER)
               ext_mode <= 1'b1;
            if (op == OP_EXT_EXIT)
               ext_mode <= 1'b0;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////
   // pin levels: acceleration only from read mode and idle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         flash_wp_high <= 1'b0;
         acceleration_voltage_level <= 1'b0;
      end
      else
      begin
         flash_wp_high <= wp_high;
         // dropping the request lowers the level at once;
         // it rises only when idle with no command set entered
         if (!accel_req)
            acceleration_voltage_level <= 1'b0;
         else if (!busy && !vol_mode && !ext_mode)
            acceleration_voltage_level <= 1'b1;
      end
   end
   ////////////////////////////////////////////////////////////////////
   // checks
   // pin levels
   a_accel_read_mode: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(acceleration_voltage_level) |-> !$past(ext_mode) && !$past(vol_mode))
      else $error("acceleration raised outside read mode");

   a_ext_no_accel: assert property (@(posedge pclk) disable iff (!presetn)
      ext_mode && !$past(acceleration_voltage_level) |-> !acceleration_voltage_level)
      else $error("acceleration in extended mode");

   // sequencer
   a_vol_cmd_mode: assert property (@(posedge pclk) disable iff (!presetn)
      state == ST_IDLE && next_state == ST_ISSUE && op_vol |-> vol_mode)
      else $error("volatile command outside its set");

   a_one_at_time: assert property (@(posedge pclk) disable iff (!presetn)
      state != ST_IDLE |=> state != ST_IDLE || $past(cyc_done))
      else $error("sequence ended without completion");

   a_ext_enter_len: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(ext_mode) |-> $past(step) == 3'd2 && $past(op) == OP_EXT_ENTER)
      else $error("extended entry not after three writes");

   a_ext_exit_len: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(ext_mode) |-> $past(step) == 3'd3 && $past(op) == OP_EXT_EXIT)
      else $error("extended exit not after four writes");

   // command data
   a_vol_prog_data: assert property (@(posedge pclk) disable iff (!presetn)
      cyc_go && op == OP_VOL_PROG && step == 3'd1 |-> cyc_d == VBIT_PROTECT)
      else $error("program volatile bit data wrong");

   a_vol_clr_data: assert property (@(posedge pclk) disable iff (!presetn)
      cyc_go && op == OP_VOL_CLEAR && step == 3'd1 |-> cyc_d == VBIT_CLEAR)
      else $error("clear volatile bit data wrong");

   a_vol_enter_code: assert property (@(posedge pclk) disable iff (!presetn)
      cyc_go && op == OP_VOL_ENTER && step == 3'd2 |-> cyc_a == ADDR_555 && cyc_d == CMD_VOL_SET)
      else $error("volatile enter code wrong");

   a_ext_exit_code: assert property (@(posedge pclk) disable iff (!presetn)
      cyc_go && op == OP_EXT_EXIT && step == 3'd3 |-> cyc_d == CMD_EXIT_00)
      else $error("extended exit data wrong");

   a_exit_clears: assert property (@(posedge pclk) disable iff (!presetn)
      state == ST_WAIT && cyc_done && op == OP_PROT_EXIT && step == 3'd1 |=> !vol_mode)
      else $error("exit did not leave command set");

   a_ext_prog_area: assert property (@(posedge pclk) disable iff (!presetn)
      cyc_go && op == OP_EXT_PROG |-> ext_mode && addr <= EXT_LAST)
      else $error("extended program outside block");

   // flash strobes
   a_strobe_excl: assert property (@(posedge pclk) disable iff (!presetn)
      !flash_we_n |-> flash_oe_n)
      else $error("write and read strobes both low");

   a_dq_drive_write: assert property (@(posedge pclk) disable iff (!presetn)
      flash_dq_oe == !flash_we_n)
      else $error("data driven outside write");
endmodule : nbp_host

// >>> tb/nbp_flash_model.sv
// Purpose: behavioural flash device answering the block protection commands
// Assumes: a write is latched while we_n is low and takes effect when it rises
// Notes: a released data bus shows the inverse of the last value read
`timescale 1ns/1ps
module nbp_flash_model
   import nbp_pkg::*;
#(
   parameter logic VOL_DEFAULT = 1'b1, // boot default of the volatile bits
   parameter logic EXT_LOCKED = 1'b0 // extended block protection bit
)
(
   input wire logic rst_n,
   input wire logic [FA_W-1:0] flash_addr,
   input wire logic [FD_W-1:0] flash_dq_out,
   output logic [FD_W-1:0] flash_dq_in,
   input wire logic flash_ce_n,
   input wire logic flash_we_n,
   input wire logic flash_oe_n,
   output int wr_count,
   output int rd_count
);
   logic vbit [128]; // per_block_volatile_bits, one per block
   // nonvolatile bits stay cleared and their lock bit untouched, so only
   // volatile bits protect
   logic [FD_W-1:0] ext_mem [256]; // extended block contents
   logic vol_mode, ext_mode, prog_pend, exit_pend;
   logic [FA_W-1:0] wa, a1, a2;
   logic [FD_W-1:0] wd, d1, d2, rd_val, last_rd;
   logic unlocked;
   ////////////////////////////////////////////////////////////////////////
   // factory contents: serial area written, customer area erased
   initial
   begin
      wr_count = 0;
      rd_count = 0;
      last_rd = 16'h0000;
      for (int i = 0; i < 256; i++)
         ext_mem[i] = (i < 128) ? 16'hC000 + 16'(i) : 16'hFFFF;
   end
   // latch address and data while the write strobe is low
   always @*
      if (!flash_we_n && !flash_ce_n)
      begin
         wa = flash_addr;
         wd = flash_dq_out;
      end
   assign unlocked = a2 == ADDR_555 && d2[7:0] == 8'hAA && a1 == ADDR_2AA && d1[7:0] == 8'h55;
   ////////////////////////////////////////////////////////////////////////
   // command decoder, one step per completed write cycle
   always @(posedge flash_we_n or negedge rst_n)
   begin
      if (!rst_n)
      begin
         vol_mode <= 1'b0;
         ext_mode <= 1'b0;
         prog_pend <= 1'b0;
         exit_pend <= 1'b0;
         a1 <= '0;
         a2 <= '0;
         for (int i = 0; i < 128; i++)
            vbit[i] <= VOL_DEFAULT;
      end
      else
      begin
         wr_count <= wr_count + 1;
         a2 <= a1;
         d2 <= d1;
         a1 <= wa;
         d1 <= wd;
         prog_pend <= 1'b0;
         exit_pend <= 1'b0;
         // no erase command exists here, the extended block is never erased
         if (prog_pend && vol_mode)
            vbit[wa[22:16]] <= wd[0];
         else if (prog_pend && ext_mode && !EXT_LOCKED)
            ext_mem[wa[7:0]] <= ext_mem[wa[7:0]] & wd;
         else if (wd[7:0] == 8'hA0 && (vol_mode || ext_mode))
            prog_pend <= 1'b1;
         else if (wd[7:0] == 8'h90 && (vol_mode || ext_mode))
            exit_pend <= 1'b1;
         else if (wd[7:0] == 8'h00 && exit_pend)
         begin
            vol_mode <= 1'b0;
            ext_mode <= 1'b0;
         end
         else if (unlocked && wa == ADDR_555 && wd[7:0] == CMD_VOL_SET[7:0])
            vol_mode <= 1'b1;
         else if (unlocked && wa == ADDR_555 && wd[7:0] == CMD_EXT_ENTER[7:0])
            ext_mode <= 1'b1;
         // anything else is not a known command and is dropped
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // read data: extended block, volatile status or array pattern
   assign rd_val = (ext_mode && flash_addr <= EXT_LAST) ? ext_mem[flash_addr[7:0]]
      : vol_mode ? (vbit[flash_addr[22:16]] ? STAT_UNPROT : STAT_PROTECTED)
      : flash_addr[15:0] ^ 16'h5A5A;
   assign flash_dq_in = (!flash_ce_n && !flash_oe_n) ? rd_val : ~last_rd;
   // remember the last value so a released bus never repeats it
   always @(posedge flash_oe_n)
   begin
      last_rd <= rd_val;
      rd_count <= rd_count + 1;
   end
endmodule : nbp_flash_model

// >>> tb/testbench.sv
// Purpose: self-checking bench for the block protection host controller
// Assumes: apb answers with zero wait states, one operation at a time
// Notes: flash side is the behavioural model, which counts bus cycles
`timescale 1ns/1ps
module testbench
   import nbp_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slv;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rv;
   logic [FA_W-1:0] flash_addr;
   logic [FD_W-1:0] flash_dq_out, flash_dq_in;
   logic flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n, flash_wp_high, acceleration_voltage_level;
   int fails = 0, compares = 0, cyc = 0, wr_count, rd_count, w0;
   localparam logic [FA_W-1:0] BLK1 = 23'h01_0000; // block 1
   localparam logic [FA_W-1:0] BLK2 = 23'h02_0000; // block 2
   nbp_host DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
      .flash_dq_in(flash_dq_in), .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n),
      .flash_oe_n(flash_oe_n), .flash_wp_high(flash_wp_high),
      .acceleration_voltage_level(acceleration_voltage_level));
   nbp_flash_model u_flash (.rst_n(presetn), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
      .flash_dq_in(flash_dq_in), .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n),
      .flash_oe_n(flash_oe_n), .wr_count(wr_count), .rd_count(rd_count));
   ////////////////////////////////////////////////////////////////////////
   // clock and hang guard
   initial
   begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fails++;
         wrap_up();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // compare, report and finish
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         fails++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task wrap_up;
      $display("comparisons %0d mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up
   // one apb transfer, then one idle edge
   task apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      r = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   // poll status until the sequencer is idle again
   task wait_idle;
      repeat (3) @(posedge pclk);
      apb(REG_STAT, 1'b0, 32'h0, rv);
      while (rv[16] !== 1'b0)
         apb(REG_STAT, 1'b0, 32'h0, rv);
   endtask : wait_idle
   task run_op(input nbp_op_t op, input logic [FA_W-1:0] a, input logic [FD_W-1:0] d);
      w0 = wr_count + rd_count;
      apb(REG_ADDR, 1'b1, {9'h0, a}, rv);
      apb(REG_DATA, 1'b1, {16'h0, d}, rv);
      apb(REG_CTRL, 1'b1, {28'h0, op}, rv);
      wait_idle();
   endtask : run_op
   function automatic logic [31:0] ncyc();
      return 32'(wr_count + rd_count - w0);
   endfunction : ncyc
   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk({26'h0, flash_ce_n, flash_we_n, flash_oe_n, flash_dq_oe, flash_wp_high,
         acceleration_voltage_level}, 32'h0000_0038);
      run_op(OP_VOL_PROG, BLK1, 16'h0);
      chk(ncyc(), 32'h0);
      run_op(OP_VOL_ENTER, 23'h0, 16'h0);
      chk(ncyc(), 32'h3);
      chk({31'h0, rv[17]}, 32'h1);
      run_op(OP_VOL_READ, BLK1, 16'h0);
      chk({16'h0, rv[15:0]}, {16'h0, STAT_UNPROT});
      for (int k = 0; k < 2; k++)
      begin
         run_op(OP_VOL_PROG, BLK1, 16'h0);
         chk(ncyc(), 32'h2);
         run_op(OP_VOL_READ, BLK1, 16'h0);
         chk({16'h0, rv[15:0]}, {16'h0, STAT_PROTECTED});
         run_op(OP_VOL_READ, BLK2, 16'h0);
         chk({16'h0, rv[15:0]}, {16'h0, STAT_UNPROT});
         run_op(OP_VOL_CLEAR, BLK1, 16'h0);
         run_op(OP_VOL_READ, BLK1, 16'h0);
         chk({16'h0, rv[15:0]}, {16'h0, STAT_UNPROT});
      end
      // second start while busy must be dropped
      w0 = wr_count + rd_count;
      apb(REG_CTRL, 1'b1, {28'h0, OP_PROT_EXIT}, rv);
      apb(REG_CTRL, 1'b1, {28'h0, OP_PROT_EXIT}, rv);
      wait_idle();
      chk(ncyc(), 32'h2);
      chk({31'h0, rv[17]}, 32'h0);
      run_op(OP_VOL_READ, BLK1, 16'h0);
      chk(ncyc(), 32'h0);
      // write protect and acceleration pins
      apb(REG_PINS, 1'b1, 32'h1, rv);
      repeat (2) @(posedge pclk);
      chk({30'h0, flash_wp_high, acceleration_voltage_level}, 32'h2);
      apb(REG_PINS, 1'b1, 32'h3, rv);
      repeat (2) @(posedge pclk);
      chk({31'h0, acceleration_voltage_level}, 32'h1);
      apb(REG_PINS, 1'b1, 32'h0, rv);
      repeat (2) @(posedge pclk);
      chk({30'h0, flash_wp_high, acceleration_voltage_level}, 32'h0);
      // extended block
      run_op(OP_EXT_ENTER, 23'h0, 16'h0);
      chk((ncyc() << 4) | {31'h0, rv[18]}, 32'h31);
      run_op(OP_EXT_READ, 23'h00_0010, 16'h0);
      chk({16'h0, rv[15:0]}, 32'h0000_C010);
      run_op(OP_EXT_PROG, 23'h00_0080, 16'h1234);
      run_op(OP_EXT_READ, 23'h00_0080, 16'h0);
      chk({16'h0, rv[15:0]}, 32'h0000_1234);
      run_op(OP_EXT_READ, 23'h00_0100, 16'h0);
      chk(ncyc(), 32'h0);
      apb(REG_PINS, 1'b1, 32'h3, rv);
      repeat (2) @(posedge pclk);
      chk({31'h0, acceleration_voltage_level}, 32'h0);
      apb(REG_PINS, 1'b1, 32'h1, rv);
      run_op(OP_EXT_EXIT, 23'h0, 16'h0);
      chk((ncyc() << 4) | {31'h0, rv[18]}, 32'h40);
      // unmapped address answers with an error
      apb(8'h14, 1'b0, 32'h0, rv);
      chk({31'h0, slv}, 32'h1);
      // reset after extended entry completes leaves extended mode
      run_op(OP_EXT_ENTER, 23'h0, 16'h0);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(REG_STAT, 1'b0, 32'h0, rv);
      chk({29'h0, rv[18:16]}, 32'h0);
      run_op(OP_EXT_READ, 23'h00_0010, 16'h0);
      chk(ncyc(), 32'h0);
      wrap_up();
   end
endmodule : testbench
